// File: core/bprps_seq.v
// Purpose: Utility-bus sequencer: system clock, reset line, power warning.
// Assumes: Backplane lines arrive active low and asynchronous.
// Notes: Open-collector lines are value plus enable; value is always low.
`timescale 1ns/1ps
`include "bprps_regs.vh"
module bprps_seq #(
    parameter HAS_MONITOR = 1,
    parameter HAS_SYSFAIL_BIT = 1,
    parameter [25:0] RST_MIN_CYC = `BPRPS_RST_MIN_CYC,
    parameter [12:0] SREL_CYC = `BPRPS_SREL_CYC,
    parameter [15:0] ACF_CYC = `BPRPS_ACF_CYC,
    parameter [21:0] DEB_CYC = `BPRPS_DEB_CYC
)
(
    input wire clk,
    input wire rst_b,
    input wire sysreset_b_in,
    input wire acfail_b_in,
    input wire button_b,
    input wire pwr_ok,
    input wire pwr_fail,
    input wire init_busy,
    input wire strobe_active,
    input wire strobe_min_done,
    input wire selftest_pass,
    output reg sysclk_out,
    output reg sysreset_b_out,
    output reg sysreset_oe,
    output reg acfail_b_out,
    output reg acfail_oe,
    output reg sysfail_b_out,
    output reg sysfail_oe,
    output reg strobe_start_inhibit,
    output reg master_release,
    output reg slave_release,
    output reg arb_grant_inhibit,
    output reg arb_release,
    output reg drv_freeze,
    output reg strobe_keep,
    output reg nonpf_stop,
    output reg reset_seen
);

localparam [7:0] SCLK_STEP = `BPRPS_SCLK_STEP;
localparam [7:0] SCLK_MOD = `BPRPS_SCLK_MOD;
localparam [12:0] NOSTART_CYC = `BPRPS_NOSTART_CYC;
localparam [12:0] MREL_CYC = `BPRPS_MREL_CYC;
localparam [2:0] ST_IDLE = `BPRPS_ST_IDLE;
localparam [2:0] ST_HOLD = `BPRPS_ST_HOLD;
localparam [2:0] ST_EXT = `BPRPS_ST_EXT;

// ----------------------------------------
// Input synchronizers
// ----------------------------------------
wire [4:0] sync_q;
wire rst_line_low;
wire acf_line_low;
wire btn_s;
wire pwr_ok_s;
wire pwr_fail_s;

bprps_sync2 #(
    .W(5),
    .INIT(5'h01)
)
u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({pwr_fail, pwr_ok, ~button_b, ~acfail_b_in, ~sysreset_b_in}),
    .q(sync_q)
);

assign rst_line_low = sync_q[0];
assign acf_line_low = sync_q[1];
assign btn_s = sync_q[2];
assign pwr_ok_s = sync_q[3];
assign pwr_fail_s = sync_q[4];

// ----------------------------------------
// System clock generator
// ----------------------------------------
// 200/16 is not whole, so a phase accumulator spreads the half periods
// as 6,6,6,7 cycles; the jitter is fine since no phase is promised.
reg [7:0] sclk_acc;
wire [8:0] sclk_sum;

assign sclk_sum = {1'b0, sclk_acc} + {1'b0, SCLK_STEP};

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        sclk_acc <= 8'h00;
        sysclk_out <= 1'b0;
    end
    else
    begin
        // Runs regardless of the reset line
        if (sclk_sum >= {1'b0, SCLK_MOD})
        begin
            sclk_acc <= sclk_sum[7:0] - SCLK_MOD;
            sysclk_out <= ~sysclk_out;
        end
        else
        begin
            sclk_acc <= sclk_sum[7:0];
        end
    end
end

// ----------------------------------------
// Push-button debounce
// ----------------------------------------
reg btn_stable;
reg btn_stable_d;
reg [21:0] deb_cnt;
wire btn_press;

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        btn_stable <= 1'b0;
        btn_stable_d <= 1'b0;
        deb_cnt <= 22'h000000;
    end
    else
    begin
        btn_stable_d <= btn_stable;
        if (btn_s == btn_stable)
        begin
            deb_cnt <= 22'h000000;
        end
        else if (deb_cnt >= DEB_CYC - 22'h000001)
        begin
            btn_stable <= btn_s;
            deb_cnt <= 22'h000000;
        end
        else
        begin
            deb_cnt <= deb_cnt + 22'h000001;
        end
    end
end

assign btn_press = btn_stable & ~btn_stable_d;

// ----------------------------------------
// Edge detection on synchronized levels
// ----------------------------------------
reg rst_line_d;
reg pwr_ok_d;
wire rst_fell;
wire pwr_return;

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        // Matches the synchronizer's reset level, so no false fall follows reset
        rst_line_d <= 1'b1;
        pwr_ok_d <= 1'b0;
    end
    else
    begin
        rst_line_d <= rst_line_low;
        pwr_ok_d <= pwr_ok_s;
    end
end

assign rst_fell = rst_line_low & ~rst_line_d;
assign pwr_return = pwr_ok_s & ~pwr_ok_d;

// ----------------------------------------
// Reset line driver
// ----------------------------------------
// Triggers arriving while already driving are ignored, so a bouncing
// button or a second event can never cut the pulse short.
reg [2:0] rst_state;
reg [2:0] next_rst_state;
reg [25:0] rst_cnt;
wire rst_req;
wire hold_done;

assign rst_req = btn_press | ((HAS_MONITOR != 0) & pwr_return) | (rst_fell & init_busy);
assign hold_done = (rst_cnt >= RST_MIN_CYC - 26'h0000001);

always @*
begin
    next_rst_state = rst_state;
    case (rst_state)
        ST_IDLE:
        begin
            if (rst_req)
            begin
                next_rst_state = ST_HOLD;
            end
        end
        ST_HOLD:
        begin
            if (hold_done)
            begin
                next_rst_state = init_busy ? ST_EXT : ST_IDLE;
            end
        end
        ST_EXT:
        begin
            if (!init_busy)
            begin
                next_rst_state = ST_IDLE;
            end
        end
        default:
        begin
            next_rst_state = ST_IDLE;
        end
    endcase
end

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        rst_state <= ST_IDLE;
        rst_cnt <= 26'h0000000;
        sysreset_b_out <= 1'b0;
        sysreset_oe <= 1'b0;
    end
    else
    begin
        rst_state <= next_rst_state;
        sysreset_b_out <= 1'b0;
        sysreset_oe <= (next_rst_state != ST_IDLE);
        if (rst_state == ST_HOLD)
        begin
            rst_cnt <= rst_cnt + 26'h0000001;
        end
        else
        begin
            rst_cnt <= 26'h0000000;
        end
    end
end

// ----------------------------------------
// Power-fail warning and request limits
// ----------------------------------------
reg [15:0] acf_cnt;

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        acf_cnt <= 16'h0000;
        acfail_b_out <= 1'b0;
        acfail_oe <= 1'b0;
        nonpf_stop <= 1'b0;
    end
    else
    begin
        acfail_b_out <= 1'b0;
        acfail_oe <= (HAS_MONITOR != 0) & pwr_fail_s;
        if (!acf_line_low)
        begin
            acf_cnt <= 16'h0000;
            nonpf_stop <= 1'b0;
        end
        else if (acf_cnt >= ACF_CYC - 16'h0001)
        begin
            nonpf_stop <= 1'b1;
        end
        else
        begin
            acf_cnt <= acf_cnt + 16'h0001;
        end
    end
end

// ----------------------------------------
// Driver release sequencing
// ----------------------------------------
// Counting starts at the later of reset falling and power in range, and
// a power loss restarts it, which covers both power-up orders.
reg [12:0] rel_cnt;
wire rel_run;

assign rel_run = rst_line_low & pwr_ok_s;

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        rel_cnt <= 13'h0000;
        strobe_start_inhibit <= 1'b0;
        master_release <= 1'b0;
        slave_release <= 1'b0;
        arb_grant_inhibit <= 1'b0;
        arb_release <= 1'b0;
        drv_freeze <= 1'b0;
        reset_seen <= 1'b0;
    end
    else
    begin
        reset_seen <= rst_line_low;
        if (!rel_run)
        begin
            rel_cnt <= 13'h0000;
            strobe_start_inhibit <= 1'b0;
            master_release <= 1'b0;
            slave_release <= 1'b0;
            arb_grant_inhibit <= 1'b0;
            arb_release <= 1'b0;
            drv_freeze <= 1'b0;
        end
        else
        begin
            if (rel_cnt < SREL_CYC)
            begin
                rel_cnt <= rel_cnt + 13'h0001;
            end
            if (rel_cnt >= NOSTART_CYC - 13'h0001)
            begin
                strobe_start_inhibit <= 1'b1;
                arb_grant_inhibit <= 1'b1;
            end
            if (rel_cnt >= MREL_CYC - 13'h0001)
            begin
                master_release <= 1'b1;
            end
            if (rel_cnt >= SREL_CYC - 13'h0001)
            begin
                slave_release <= 1'b1;
                arb_release <= 1'b1;
                drv_freeze <= 1'b1;
            end
        end
    end
end

// ----------------------------------------
// Strobe keep and system-fail driver
// ----------------------------------------
reg sysfail_bit;

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        strobe_keep <= 1'b0;
        sysfail_bit <= 1'b1;
        sysfail_b_out <= 1'b0;
        sysfail_oe <= 1'b0;
    end
    else
    begin
        sysfail_b_out <= 1'b0;
        if (rst_fell & pwr_ok_s & strobe_active)
        begin
            strobe_keep <= 1'b1;
        end
        else if (strobe_min_done)
        begin
            strobe_keep <= 1'b0;
        end
        // Set on reset fall wins over a self-test pass in the same cycle
        if (rst_fell)
        begin
            sysfail_bit <= 1'b1;
        end
        else if (selftest_pass)
        begin
            sysfail_bit <= 1'b0;
        end
        sysfail_oe <= (HAS_SYSFAIL_BIT != 0) & (sysfail_bit | rst_fell);
    end
end

endmodule

// File: core/bprps_regs.vh
// Purpose: Constants for the backplane reset and power sequencer.
// Assumes: Local clock of 200 MHz; all times derive from it.
// Notes: Holds definitions only.
`ifndef BPRPS_REGS_VH
`define BPRPS_REGS_VH
`define BPRPS_CLK_MHZ 200
`define BPRPS_SYSCLK_MHZ 16
`define BPRPS_SCLK_STEP (2 * `BPRPS_SYSCLK_MHZ)
`define BPRPS_SCLK_MOD `BPRPS_CLK_MHZ
`define BPRPS_SYNC_LAT 3
`define BPRPS_T_RST_MIN_MS 200
`define BPRPS_RST_MIN_CYC (`BPRPS_T_RST_MIN_MS * 1000 * `BPRPS_CLK_MHZ)
`define BPRPS_T_NOSTART_US 5
`define BPRPS_T_MREL_US 20
`define BPRPS_T_SREL_US 30
`define BPRPS_NOSTART_CYC (`BPRPS_T_NOSTART_US * `BPRPS_CLK_MHZ - `BPRPS_SYNC_LAT)
`define BPRPS_MREL_CYC (`BPRPS_T_MREL_US * `BPRPS_CLK_MHZ - `BPRPS_SYNC_LAT)
`define BPRPS_SREL_CYC (`BPRPS_T_SREL_US * `BPRPS_CLK_MHZ - `BPRPS_SYNC_LAT)
`define BPRPS_T_ACF_US 200
`define BPRPS_ACF_CYC (`BPRPS_T_ACF_US * `BPRPS_CLK_MHZ)
`define BPRPS_T_SYSFAIL_MS 50
`define BPRPS_T_DEB_MS 10
`define BPRPS_DEB_CYC (`BPRPS_T_DEB_MS * 1000 * `BPRPS_CLK_MHZ)
`define BPRPS_ST_IDLE 3'h1
`define BPRPS_ST_HOLD 3'h2
`define BPRPS_ST_EXT 3'h4
`endif

// File: core/bprps_sync2.v
// Purpose: Two-flop synchronizer for a group of asynchronous levels.
// Assumes: Each bit is an independent level; no bus coherency.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module bprps_sync2 #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
)
(
    input wire clk,
    input wire rst_b,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
reg [W-1:0] meta;
always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        meta <= INIT;
        q <= INIT;
    end
    else
    begin
        meta <= d;
        q <= meta;
    end
end
endmodule

// File: bench/bprps_seq_assertions.sv
// Purpose: Port-level checks of the utility-bus sequencer.
// Assumes: Backplane inputs are the wired line levels.
// Notes: Pin-side counters give deadlines one register stage of slack.
`timescale 1ns/1ps
module bprps_chk #(
    parameter [25:0] RST_MIN_CYC = 26'd200,
    parameter [15:0] ACF_CYC = 16'd50
)
(
    input wire clk,
    input wire rst_b,
    input wire sysreset_b_in,
    input wire acfail_b_in,
    input wire pwr_ok,
    input wire pwr_fail,
    input wire init_busy,
    input wire strobe_min_done,
    input wire sysclk_out,
    input wire sysreset_oe,
    input wire acfail_oe,
    input wire sysfail_oe,
    input wire strobe_start_inhibit,
    input wire master_release,
    input wire slave_release,
    input wire drv_freeze,
    input wire strobe_keep,
    input wire nonpf_stop,
    input wire reset_seen
);
// ----
// Timers
// ----
reg [25:0] hold_n;
reg [15:0] low_n;
reg [15:0] acf_n;
always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        hold_n <= 26'h0;
        low_n <= 16'h0;
        acf_n <= 16'h0;
    end
    else
    begin
        hold_n <= sysreset_oe ? hold_n + 26'h1 : 26'h0;
        low_n <= (!sysreset_b_in && pwr_ok) ? low_n + 16'h1 : 16'h0;
        acf_n <= !acfail_b_in ? acf_n + 16'h1 : 16'h0;
    end
end
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
sequence s_half;
    $stable(sysclk_out) [*5] ##[1:2] $changed(sysclk_out);
endsequence
a_sysclk_free: assert property ($changed(sysclk_out) |=> s_half)
    else $error("clock half period");
a_hold_min: assert property ($fell(sysreset_oe) |-> hold_n >= RST_MIN_CYC)
    else $error("reset pulse short");
a_busy_extend: assert property (sysreset_oe && init_busy |=> sysreset_oe)
    else $error("reset dropped while busy");
a_pwr_return: assert property ($rose(pwr_ok) && !sysreset_oe |-> ##[2:6] sysreset_oe)
    else $error("no reset on power return");
a_release_5us: assert property (low_n > 16'd1001 |-> strobe_start_inhibit)
    else $error("strobe inhibit late");
a_release_20us: assert property (low_n > 16'd4001 |-> master_release && strobe_start_inhibit)
    else $error("master release late");
a_release_30us: assert property (low_n > 16'd6001 |-> slave_release && drv_freeze)
    else $error("slave release late");
a_freeze_hold: assert property (drv_freeze && reset_seen && pwr_ok |=> drv_freeze || !reset_seen)
    else $error("freeze lost");
a_warn_follow: assert property ($rose(pwr_fail) |-> ##[2:6] acfail_oe)
    else $error("warning not driven");
a_nonpf_late: assert property (acf_n > ACF_CYC + 16'd8 |-> nonpf_stop)
    else $error("stop flag late");
a_nonpf_early: assert property ($rose(nonpf_stop) |-> acf_n >= ACF_CYC)
    else $error("stop flag early");
a_sysfail_set: assert property ($rose(reset_seen) |-> ##[0:3] sysfail_oe)
    else $error("system fail not driven");
a_sync_seen: assert property (!sysreset_b_in [*3] |=> reset_seen)
    else $error("reset not seen");
a_strobe_keep: assert property (strobe_keep && !strobe_min_done && reset_seen && pwr_ok |=> strobe_keep)
    else $error("strobe keep dropped");
endmodule
bind bprps_seq bprps_chk #(.RST_MIN_CYC(RST_MIN_CYC), .ACF_CYC(ACF_CYC)) u_chk (.*);

// File: bench/bprps_far.sv
// Purpose: Other boards and a second monitor on the wired lines.
// Assumes: Pull-ups on both lines.
// Notes: A reset pull is held for MINP more system clock rises after it ends.
`timescale 1ns/1ps
module bprps_far #(
    parameter [15:0] MINP = 16'h0010
)
(
    input wire clk,
    input wire sysclk,
    input wire pull_rst,
    input wire pull_acf,
    input wire rst_oe,
    input wire acf_oe,
    output wire rst_line,
    output wire acf_line
);
reg [15:0] left = 16'h0000;
reg sc_d = 1'b0;
// Counts system clock edges only; its phase is never relied on
always @(posedge clk)
begin
    sc_d <= sysclk;
    if (pull_rst)
        left <= MINP;
    else if (sysclk && !sc_d && left != 16'h0000)
        left <= left - 16'h0001;
end
assign rst_line = !(pull_rst || left != 16'h0000 || rst_oe);
assign acf_line = !(pull_acf || acf_oe);
endmodule

// File: bench/bprps_seq_test.sv
// Purpose: Self-checking bench for the utility-bus sequencer.
// Assumes: Shortened hold, warning and debounce counts.
// Notes: Outputs are sampled on the falling clock edge.
`timescale 1ns/1ps
module bprps_seq_test;
localparam integer HOLD = 200;
localparam integer ACFC = 50;
reg clk = 1'b0;
reg rst_b = 1'b0;
reg pull_rst = 1'b0;
reg pull_acf = 1'b0;
reg button_b = 1'b1;
reg pwr_ok = 1'b0;
reg pwr_fail = 1'b0;
reg init_busy = 1'b0;
reg strobe_active = 1'b0;
reg strobe_min_done = 1'b0;
reg selftest_pass = 1'b0;
reg sc = 1'b0;
wire sysreset_b_in, acfail_b_in, sysclk_out, sysreset_b_out, sysreset_oe, acfail_b_out, acfail_oe;
wire sysfail_b_out, sysfail_oe, strobe_start_inhibit, master_release, slave_release, arb_grant_inhibit;
wire arb_release, drv_freeze, strobe_keep, nonpf_stop, reset_seen;
integer n_errors = 0;
integer tests_run = 0;
integer seed = 93;
integer cyc = 0;
integer run = 0;
integer last_len = 0;
integer i, k, len, t_inh, t_mst, t_slv, rises;
bprps_seq #(.RST_MIN_CYC(26'd200), .SREL_CYC(13'd5997), .ACF_CYC(16'd50), .DEB_CYC(22'd8)) dut (.*);
bprps_far far (.clk(clk), .sysclk(sysclk_out), .pull_rst(pull_rst), .pull_acf(pull_acf), .rst_oe(sysreset_oe),
    .acf_oe(acfail_oe), .rst_line(sysreset_b_in), .acf_line(acfail_b_in));
function integer sysclk_rises(input integer cycles);
    sysclk_rises = cycles * 16 / 200;
endfunction
function integer deadline(input integer us);
    deadline = us * 200 + 1;
endfunction
task check(input [8*8:1] what, input [31:0] seen, input [31:0] exp);
begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s expected %0h seen %0h", what, exp, seen);
    end
end
endtask
task tally_and_finish;
begin
    if (n_errors == 0 && tests_run > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
end
endtask
task tick(input integer n);
    repeat (n) @(negedge clk);
endtask
task wait_fall;
begin
    last_len = 0;
    for (k = 0; k < 600 && sysreset_oe !== 1'b1; k = k + 1) @(negedge clk);
    for (k = 0; k < 2000 && sysreset_oe === 1'b1; k = k + 1) @(negedge clk);
    tick(2);
end
endtask
task deadline_run(input chk_keep);
begin
    t_inh = 0;
    t_mst = 0;
    t_slv = 0;
    rises = 0;
    sc = sysclk_out;
    for (i = 1; i <= 6200; i = i + 1)
    begin
        @(posedge clk) strobe_min_done <= (i == 3000);
        @(negedge clk);
        if (strobe_start_inhibit === 1'b1 && arb_grant_inhibit === 1'b1 && t_inh == 0) t_inh = i;
        if (master_release === 1'b1 && t_mst == 0) t_mst = i;
        if (slave_release === 1'b1 && arb_release === 1'b1 && drv_freeze === 1'b1 && t_slv == 0) t_slv = i;
        if (sysclk_out === 1'b1 && sc === 1'b0) rises = rises + 1;
        sc = sysclk_out;
        if (chk_keep && i == 2000) check("keep", strobe_keep, 1);
        if (chk_keep && i == 3100) check("keepend", strobe_keep, 0);
    end
    check("t5us", t_inh > 0 && t_inh <= deadline(5), 1);
    check("t20us", t_mst > t_inh && t_mst <= deadline(20), 1);
    check("t30us", t_slv > t_mst && t_slv <= deadline(30), 1);
    check("sysclk", rises, sysclk_rises(6200));
    check("seen", reset_seen, 1);
end
endtask
initial
    forever #2.5 clk = ~clk;
always @(posedge clk)
begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
        n_errors = n_errors + 1;
        tally_and_finish;
    end
end
// Length of each reset pulse driven by the block
always @(negedge clk)
begin
    if (sysreset_oe === 1'b1)
        run <= run + 1;
    else
    begin
        if (run != 0)
            last_len <= run;
        run <= 0;
    end
end
initial
begin
    repeat (20) @(negedge clk);
    check("inreset", {sysreset_oe, acfail_oe, drv_freeze, nonpf_stop}, 0);
    @(posedge clk) rst_b <= 1'b1;
    tick(4);
    @(posedge clk) pwr_ok <= 1'b1;
    wait_fall;
    check("pwrret", last_len, HOLD);
    // ----
    // Push-button with bounce shorter than the filter
    // ----
    for (i = 0; i < 6; i = i + 1)
    begin
        @(posedge clk) button_b <= 1'b0;
        tick(1 + {$random(seed)} % 5);
        @(posedge clk) button_b <= 1'b1;
        tick(1 + {$random(seed)} % 5);
    end
    check("bounce", sysreset_oe, 0);
    @(posedge clk) button_b <= 1'b0;
    tick(30);
    @(posedge clk) button_b <= 1'b1;
    tick(60);
    @(posedge clk) button_b <= 1'b0;
    tick(30);
    @(posedge clk) button_b <= 1'b1;
    wait_fall;
    check("button", last_len, HOLD);
    tick(20);
    check("norepeat", sysreset_oe, 0);
    @(posedge clk) init_busy <= 1'b1;
    pull_rst <= 1'b1;
    @(posedge clk) pull_rst <= 1'b0;
    tick(450);
    @(posedge clk) init_busy <= 1'b0;
    wait_fall;
    check("longinit", last_len > 440 && last_len < 460, 1);
    @(posedge clk) selftest_pass <= 1'b1;
    @(posedge clk) selftest_pass <= 1'b0;
    strobe_active <= 1'b1;
    pull_rst <= 1'b1;
    deadline_run(1'b1);
    check("sysfail", sysfail_oe, 1);
    check("oclevel", {sysreset_b_out, acfail_b_out, sysfail_b_out}, 0);
    @(posedge clk) pwr_ok <= 1'b0;
    tick(10);
    check("pwrexit", {master_release, slave_release, drv_freeze}, 0);
    @(posedge clk) pwr_ok <= 1'b1;
    deadline_run(1'b0);
    @(posedge clk) pull_rst <= 1'b0;
    tick(300);
    check("freed", {strobe_start_inhibit, slave_release, drv_freeze}, 0);
    // ----
    // Power-fail warning from either source
    // ----
    for (i = 0; i < 6; i = i + 1)
    begin
        len = ({$random(seed)} % 2) ? 20 : 120;
        @(posedge clk) pwr_fail <= i[0];
        pull_acf <= !i[0];
        tick(len);
        check("warn", acfail_oe, i[0]);
        check("stop", nonpf_stop, len > ACFC + 8);
        @(posedge clk) pwr_fail <= 1'b0;
        pull_acf <= 1'b0;
        tick(10);
        check("resume", {acfail_oe, nonpf_stop}, 0);
    end
    tally_and_finish;
end
endmodule
